// ### rtl/dual_timer.sv
`timescale 1ns/100ps
`include "dual_timer_map.svh"
module dual_timer
    import dual_timer_pkg::*;
#(
    parameter int unsigned MS_DIV = `MS_CYCLES,
    parameter int unsigned SIXTEENTH_DIV = `SIXTEENTH_CYCLES,
    parameter int unsigned SEC_DIV = `SEC_CYCLES,
    parameter int unsigned MIN_DIV = `SEC_PER_MIN
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    input wire logic reload_event,
    input wire logic [15:0] pm_event_smi_enable_reg,
    output logic [15:0] pm_event_status_reg,
    input wire logic [15:0] status_clear,
    output logic smi_req
);
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] load_a;
        logic [7:0] load_b;
        timer_state_t ta;
        timer_state_t tb;
        logic [15:0] status;
        logic smi;
        logic [7:0] rdata;
    } top_state_t;
    top_state_t st, next_st;

    timer_tick_if ticks();

    timer_tick_gen #(
        .MS_DIV(MS_DIV),
        .SIXTEENTH_DIV(SIXTEENTH_DIV),
        .SEC_DIV(SEC_DIV),
        .MIN_DIV(MIN_DIV)
    ) u_ticks (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ticks(ticks)
    );

    // pick the tick pulse for a select code; timer a uses ms on code 01, b uses 1/16 s
    // every pulse comes in as an argument: a continuous assignment only wakes on its arguments
    function automatic logic pick_tick(input logic [1:0] sel, input logic fast, input logic slow_sec,
                                       input logic slow_min);
        logic t;
        t = 1'b0;
        case (sel)
            `TICK_OFF: t = 1'b0;
            `TICK_FAST: t = fast;
            `TICK_SEC: t = slow_sec;
            `TICK_MIN: t = slow_min;
            default: t = 1'b0;
        endcase
        return t;
    endfunction : pick_tick

    // one timer step: start, event reload, decrement, expiry
    function automatic timer_state_t step(input timer_state_t t, input logic start_rise, input logic start,
                                          input logic [7:0] load, input logic auto_rl, input logic tick);
        timer_state_t n;
        n = t;
        n.expire = 1'b0;
        if (start_rise) begin
            n.run = 1'b1;
            n.count = load;
        end else if (!start) begin
            n.run = 1'b0;
        end else if (t.run && reload_event) begin
            n.count = load;
        end else if (t.run && tick) begin
            if (t.count == 8'h01 || t.count == 8'h00) begin
                n.expire = 1'b1;
                n.count = auto_rl ? load : 8'h00;
                n.run = auto_rl;
            end else begin
                n.count = t.count - 8'h01;
            end
        end
        return n;
    endfunction : step

    logic wr_ctl;
    logic start_a_rise;
    logic start_b_rise;
    logic tick_a;
    logic tick_b;
    assign wr_ctl = cfg_wr && cfg_addr == `OFS_CONTROL;
    assign start_a_rise = wr_ctl && cfg_wdata[`CTL_A_START] && !st.ctl[`CTL_A_START];
    assign start_b_rise = wr_ctl && cfg_wdata[`CTL_B_START] && !st.ctl[`CTL_B_START];
    assign tick_a = pick_tick(st.ctl[`CTL_A_TICK_HI:`CTL_A_TICK_LO], ticks.tick_ms, ticks.tick_sec,
                              ticks.tick_min);
    assign tick_b = pick_tick(st.ctl[`CTL_B_TICK_HI:`CTL_B_TICK_LO], ticks.tick_sixteenth, ticks.tick_sec,
                              ticks.tick_min);

    // register writes, timer stepping, sticky status and reads
    always_comb begin
        next_st = st;
        if (wr_ctl) begin
            next_st.ctl = cfg_wdata;
        end
        if (cfg_wr && cfg_addr == `OFS_A_COUNT) begin
            next_st.load_a = cfg_wdata;
        end
        if (cfg_wr && cfg_addr == `OFS_B_COUNT) begin
            next_st.load_b = cfg_wdata;
        end
        // a tick select of 00 simply never ticks, so the count holds unless a start write loads it or reload_event reloads a running timer
        next_st.ta = step(st.ta, start_a_rise, next_st.ctl[`CTL_A_START], st.load_a,
                          st.ctl[`CTL_A_RELOAD], tick_a);
        next_st.tb = step(st.tb, start_b_rise, next_st.ctl[`CTL_B_START], st.load_b,
                          st.ctl[`CTL_B_RELOAD], tick_b);
        // clear first, then the set wins over a same-cycle clear
        next_st.status = st.status & ~status_clear;
        if (st.ta.expire) begin
            next_st.status[`STS_A_BIT] = 1'b1;
        end
        if (st.tb.expire) begin
            next_st.status[`STS_B_BIT] = 1'b1;
        end
        next_st.smi = (st.ta.expire && pm_event_smi_enable_reg[`STS_A_BIT]) ||
                      (st.tb.expire && pm_event_smi_enable_reg[`STS_B_BIT]);
        next_st.rdata = st.rdata;
        if (cfg_rd) begin
            case (cfg_addr)
                `OFS_CONTROL: next_st.rdata = st.ctl;
                `OFS_A_COUNT: next_st.rdata = st.ta.count;
                `OFS_B_COUNT: next_st.rdata = st.tb.count;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.ctl <= `CTL_RESET;
            st.load_a <= `COUNT_RESET;
            st.load_b <= `COUNT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign cfg_rdata = st.rdata;
    assign pm_event_status_reg = st.status;
    assign smi_req = st.smi;

    start_loads_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        start_a_rise |=> st.ta.run && st.ta.count == $past(st.load_a))
        else $error("timer a start did not load count");
    event_reload_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ta.run && st.ctl[`CTL_A_START] && !wr_ctl && reload_event |=> st.ta.count == $past(st.load_a))
        else $error("timer a not reloaded by event");
    status_a_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ta.expire |=> pm_event_status_reg[`STS_A_BIT])
        else $error("timer a status not set");
    smi_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        smi_req |-> $past(st.ta.expire && pm_event_smi_enable_reg[`STS_A_BIT]) ||
                    $past(st.tb.expire && pm_event_smi_enable_reg[`STS_B_BIT]))
        else $error("smi without enabled expiry");
    stop_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ta.expire && !st.ctl[`CTL_A_RELOAD] && !$past(wr_ctl) |-> !st.ta.run && st.ta.count == 8'h00)
        else $error("timer a did not stop at zero");
    freeze_off_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ctl[`CTL_A_TICK_HI:`CTL_A_TICK_LO] == `TICK_OFF && !reload_event && !wr_ctl
        |=> st.ta.count == $past(st.ta.count))
        else $error("timer a moved with tick off");
    auto_reload_b_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.tb.expire && st.ctl[`CTL_B_RELOAD] && !$past(wr_ctl) |-> st.tb.run && st.tb.count == $past(st.load_b))
        else $error("timer b did not auto reload");
    status_b_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.tb.expire |=> pm_event_status_reg[`STS_B_BIT])
        else $error("timer b status not set");
    read_live_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg_rd && cfg_addr == `OFS_A_COUNT |=> cfg_rdata == $past(st.ta.count))
        else $error("timer a read not live count");

    // second set: timer b mirrors, smi and sticky status, tick sources and idle hold
    smi_enabled_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ta.expire && pm_event_smi_enable_reg[`STS_A_BIT] |=> smi_req)
        else $error("enabled timer a expiry gave no smi");
    status_sticky_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        pm_event_status_reg[`STS_A_BIT] && !status_clear[`STS_A_BIT] |=> pm_event_status_reg[`STS_A_BIT])
        else $error("timer a status dropped without clear");
    read_live_b_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg_rd && cfg_addr == `OFS_B_COUNT |=> cfg_rdata == $past(st.tb.count))
        else $error("timer b read not live count");
    load_write_b_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg_wr && cfg_addr == `OFS_B_COUNT |=> st.load_b == $past(cfg_wdata))
        else $error("timer b load value not stored");
    start_loads_b_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        start_b_rise |=> st.tb.run && st.tb.count == $past(st.load_b))
        else $error("timer b start did not load count");
    stop_zero_b_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.tb.expire && !st.ctl[`CTL_B_RELOAD] && !$past(wr_ctl) |-> !st.tb.run && st.tb.count == 8'h00)
        else $error("timer b did not halt at zero");
    rearm_ta_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ta.expire && st.ctl[`CTL_A_RELOAD] && !$past(wr_ctl) |-> st.ta.run && st.ta.count == $past(st.load_a))
        else $error("timer a did not auto reload");
    tick_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ta.run && st.ctl[`CTL_A_START] && !wr_ctl && !reload_event && tick_a && st.ta.count > 8'h01
        |=> st.ta.count == $past(st.ta.count) - 8'h01)
        else $error("timer a did not step by one");
    idle_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !st.ta.run && !wr_ctl |=> st.ta.count == $past(st.ta.count))
        else $error("stopped timer a count moved");
    minute_tick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ctl[`CTL_A_TICK_HI:`CTL_A_TICK_LO] == `TICK_MIN |-> tick_a == ticks.tick_min)
        else $error("timer a minute tick wrong");
    second_tick_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        st.ctl[`CTL_B_TICK_HI:`CTL_B_TICK_LO] == `TICK_SEC |-> tick_b == ticks.tick_sec)
        else $error("timer b second tick wrong");
endmodule : dual_timer

// ### rtl/dual_timer_map.svh
`ifndef DUAL_TIMER_MAP_SVH
`define DUAL_TIMER_MAP_SVH

// configuration byte offsets
`define OFS_CONTROL 8'h98
`define OFS_A_COUNT 8'h99
`define OFS_B_COUNT 8'h9a

// control register layout
`define CTL_B_START 7
`define CTL_B_RELOAD 6
`define CTL_B_TICK_HI 5
`define CTL_B_TICK_LO 4
`define CTL_A_START 3
`define CTL_A_RELOAD 2
`define CTL_A_TICK_HI 1
`define CTL_A_TICK_LO 0
`define CTL_RESET 8'h10
`define COUNT_RESET 8'h00

// event status / enable bit positions
`define STS_A_BIT 12
`define STS_B_BIT 13

// tick select encodings
`define TICK_OFF 2'h0
`define TICK_FAST 2'h1
`define TICK_SEC 2'h2
`define TICK_MIN 2'h3

// tick periods
`define CLK_PERIOD_NS 100
`define MS_NS 1000000
`define SIXTEENTH_NS 62500000
`define SEC_NS 1000000000
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define SIXTEENTH_CYCLES (`SIXTEENTH_NS / `CLK_PERIOD_NS)
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)
`define SEC_PER_MIN 60

`endif

// ### rtl/dual_timer_pkg.sv
package dual_timer_pkg;
    typedef struct packed {
        logic run;
        logic [7:0] count;
        logic expire;
    } timer_state_t;
endpackage : dual_timer_pkg

// ### rtl/timer_tick_if.sv
`timescale 1ns/100ps
interface timer_tick_if;
    logic tick_ms;
    logic tick_sixteenth;
    logic tick_sec;
    logic tick_min;
    modport source (output tick_ms, output tick_sixteenth, output tick_sec, output tick_min);
    modport sink (input tick_ms, input tick_sixteenth, input tick_sec, input tick_min);
endinterface : timer_tick_if

// ### rtl/timer_tick_gen.sv
`timescale 1ns/100ps
`include "dual_timer_map.svh"
module timer_tick_gen #(
    parameter int unsigned MS_DIV = `MS_CYCLES,
    parameter int unsigned SIXTEENTH_DIV = `SIXTEENTH_CYCLES,
    parameter int unsigned SEC_DIV = `SEC_CYCLES,
    parameter int unsigned MIN_DIV = `SEC_PER_MIN
) (
    input wire logic clk_sys,
    input wire logic nrst,
    timer_tick_if.source ticks
);
    typedef struct packed {
        logic [31:0] ms_cnt;
        logic [31:0] s16_cnt;
        logic [31:0] sec_cnt;
        logic [7:0] min_cnt;
        logic ms;
        logic s16;
        logic sec;
        logic min;
    } tick_state_t;
    tick_state_t st, next_st;

    // free dividers, each a one-cycle pulse; minute counts second pulses
    always_comb begin
        next_st = st;
        next_st.ms = 1'b0;
        next_st.s16 = 1'b0;
        next_st.sec = 1'b0;
        next_st.min = 1'b0;
        next_st.ms_cnt = st.ms_cnt + 32'h1;
        if (st.ms_cnt >= 32'(MS_DIV - 1)) begin
            next_st.ms_cnt = 32'h0;
            next_st.ms = 1'b1;
        end
        next_st.s16_cnt = st.s16_cnt + 32'h1;
        if (st.s16_cnt >= 32'(SIXTEENTH_DIV - 1)) begin
            next_st.s16_cnt = 32'h0;
            next_st.s16 = 1'b1;
        end
        next_st.sec_cnt = st.sec_cnt + 32'h1;
        if (st.sec_cnt >= 32'(SEC_DIV - 1)) begin
            next_st.sec_cnt = 32'h0;
            next_st.sec = 1'b1;
            next_st.min_cnt = st.min_cnt + 8'h1;
            if (st.min_cnt >= 8'(MIN_DIV - 1)) begin
                next_st.min_cnt = 8'h0;
                next_st.min = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ticks.tick_ms = st.ms;
    assign ticks.tick_sixteenth = st.s16;
    assign ticks.tick_sec = st.sec;
    assign ticks.tick_min = st.min;
endmodule : timer_tick_gen

// ### tb/tb_dual_timer.sv
`timescale 1ns/100ps
module tb_dual_timer
    import dual_timer_pkg::*;
;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic reload_event = 1'b0;
    logic [15:0] pm_event_smi_enable_reg = 16'h0000;
    logic [15:0] pm_event_status_reg;
    logic [15:0] status_clear = 16'h0000;
    logic smi_req;
    int fail_count = 0;
    int checked = 0;
    int smi_cnt = 0;
    int aper[4] = '{0, 4, 8, 24};
    int bper[4] = '{0, 6, 8, 24};
    logic [7:0] c1;
    logic [7:0] c2;
    int n;

    // short dividers so every tick base fits in the run: ms 4, 1/16 s 6, s 8, min 3 s
    dual_timer #(.MS_DIV(4), .SIXTEENTH_DIV(6), .SEC_DIV(8), .MIN_DIV(3)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .reload_event(reload_event),
        .pm_event_smi_enable_reg(pm_event_smi_enable_reg), .pm_event_status_reg(pm_event_status_reg),
        .status_clear(status_clear), .smi_req(smi_req));

    // 100 ns clock
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    // smi pulses are one cycle wide, so count them on every edge
    always @(posedge clk_sys) begin
        if (smi_req === 1'b1) smi_cnt <= smi_cnt + 1;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask : wr

    // read data lands one cycle after the strobe edge
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge clk_sys);
        cfg_rd <= 1'b0;
        #1;
        d = cfg_rdata;
    endtask : rd

    task rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rdchk

    task clr;
        @(posedge clk_sys);
        status_clear <= 16'h3000;
        @(posedge clk_sys);
        status_clear <= 16'h0000;
        #1;
    endtask : clr

    // bounded wait for a status bit; running out ends the run
    task wait_sts(input int b, input int lim, output int cnt);
        cnt = 0;
        while (pm_event_status_reg[b] !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            cnt++;
            if (cnt > lim) begin
                fail_count++;
                $display("Error at %0t: got %h expected %h", $time, pm_event_status_reg, 16'h1 << b);
                give_verdict();
            end
        end
    endtask : wait_sts

    // load 4, one-shot run on the chosen tick base, then confirm it stays stopped
    task run_tmr(input logic b, input logic [1:0] sel, input int per);
        int e;
        int s0;
        clr();
        wr(b ? 8'h9a : 8'h99, 8'h04);
        wr(8'h98, 8'h00);
        s0 = smi_cnt;
        wr(8'h98, b ? {2'b10, sel, 4'h0} : {4'h0, 2'b10, sel});
        wait_sts(b ? 13 : 12, 6 * per + 10, e);
        chk({15'h0, e >= 3 * per && e <= 4 * per + 6}, 16'h1);
        rdchk(b ? 8'h9a : 8'h99, 8'h00);
        chk(16'(smi_cnt - s0), {15'h0, pm_event_smi_enable_reg[b ? 13 : 12]});
        clr();
        repeat (3 * per) @(posedge clk_sys);
        #1;
        chk(pm_event_status_reg, 16'h0000);
    endtask : run_tmr

    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        rdchk(8'h98, 8'h10);
        rdchk(8'h99, 8'h00);
        rdchk(8'h9a, 8'h00);
        rdchk(8'h55, 8'h00);
        // a write to an unmapped byte leaves the control register alone
        wr(8'h55, 8'hff);
        rdchk(8'h98, 8'h10);
        // every tick base on both timers, smi enabled
        @(posedge clk_sys);
        pm_event_smi_enable_reg <= 16'h3000;
        for (int s = 1; s < 4; s++) begin
            run_tmr(1'b0, 2'(s), aper[s]);
            run_tmr(1'b1, 2'(s), bper[s]);
        end
        // status only, no smi
        @(posedge clk_sys);
        pm_event_smi_enable_reg <= 16'h0000;
        run_tmr(1'b0, 2'h1, 4);
        run_tmr(1'b1, 2'h1, 6);
        @(posedge clk_sys);
        pm_event_smi_enable_reg <= 16'h3000;
        // a held reload event keeps the count at its load value
        wr(8'h99, 8'h03);
        reload_event <= 1'b1;
        wr(8'h98, 8'h00);
        wr(8'h98, 8'h09);
        rdchk(8'h98, 8'h09);
        repeat (40) @(posedge clk_sys);
        rdchk(8'h99, 8'h03);
        chk(pm_event_status_reg, 16'h0000);
        @(posedge clk_sys);
        reload_event <= 1'b0;
        wait_sts(12, 30, n);
        // tick select off freezes a running count without clearing it
        clr();
        wr(8'h99, 8'h50);
        wr(8'h98, 8'h00);
        wr(8'h98, 8'h09);
        repeat (20) @(posedge clk_sys);
        wr(8'h98, 8'h08);
        rd(8'h99, c1);
        repeat (40) @(posedge clk_sys);
        rd(8'h99, c2);
        chk({8'h00, c2}, {8'h00, c1});
        chk({15'h0, c1 >= 8'h48 && c1 <= 8'h4c}, 16'h1);
        // auto reload expires again without restarting
        for (int b = 0; b < 2; b++) begin
            clr();
            wr(b ? 8'h9a : 8'h99, 8'h02);
            wr(8'h98, 8'h00);
            wr(8'h98, b ? 8'h50 + 8'h80 : 8'h0d);
            wait_sts(b ? 13 : 12, 40, n);
            clr();
            wait_sts(b ? 13 : 12, b ? 32 : 24, n);
        end
        give_verdict();
    end
endmodule : tb_dual_timer
